// file: hw/pllc_device.sv
// serial slave of the clock synthesizer with divider and multiplier selection
// Operation
// - start opens transfer, device begins address
// - stop ends transfer, device returns idle
// - data changes only while clock low
// - acknowledge held low across ack clock
// - each segment eight bits plus ack
// - address and direction first, matched address acked
// - direction bit zero writes, one reads
// - receiver of each byte acknowledges it
// - own address 1100101, msb first
// - two dummy bytes discarded before configuration
// - three latches only, extra bytes ignored
// - byte0 bypass, select, ref count; byte1 feedback
// - select high uses programmed counts
// - feedback (p+3)*2, reference q+2
// - bypass forces reference divider to one
// - select low uses select pin table
// - pin low x16, pin high x8
// - output equals crystal times feedback over reference
// - output enable pin gates differential clock
// - lines only pulled low or released
`timescale 1ns/1ps
module pllc_device
   import pllc_pkg::*;
#(
   parameter logic [31:0] XTAL_KHZ = PLLC_XTAL_KHZ
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   pllc_link_if.device link,
   input wire logic mult_select_pin,
   input wire logic output_enable_pin,
   input wire logic pll_clk,
   output logic ref_count_bypass,
   output logic serial_ratio_select,
   output logic [5:0] ref_count,
   output logic [7:0] feedback_divider_count,
   output logic [7:0] reserved_config_byte,
   output logic [9:0] fb_divider,
   output logic [6:0] ref_divider,
   output logic [31:0] synth_freq_khz,
   output logic clock_out,
   output logic clock_out_complement
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic scl_m1_q, scl_m2_q, scl_p_q, sda_m1_q, sda_m2_q, sda_p_q;
   logic sel_m1_q, sel_m2_q, oe_m1_q, oe_m2_q;
   // select pin resets high to mirror its pull-up
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_m1_q <= 1'b1;
         scl_m2_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m1_q <= 1'b1;
         sda_m2_q <= 1'b1;
         sda_p_q <= 1'b1;
         sel_m1_q <= 1'b1;
         sel_m2_q <= 1'b1;
         oe_m1_q <= 1'b0;
         oe_m2_q <= 1'b0;
      end else begin
         scl_m1_q <= link.scl_line;
         scl_m2_q <= scl_m1_q;
         scl_p_q <= scl_m2_q;
         sda_m1_q <= link.sda_line;
         sda_m2_q <= sda_m1_q;
         sda_p_q <= sda_m2_q;
         sel_m1_q <= mult_select_pin;
         sel_m2_q <= sel_m1_q;
         oe_m1_q <= output_enable_pin;
         oe_m2_q <= oe_m1_q;
      end
   end
   // ---------------------------------------------------------------
   // line events
   // ---------------------------------------------------------------
   logic scl_rise, scl_fall, start_seen, stop_seen;
   // edges judged only on the second stage and the stage after it
   assign scl_rise = scl_m2_q & ~scl_p_q;
   assign scl_fall = ~scl_m2_q & scl_p_q;
   assign start_seen = scl_m2_q & scl_p_q & sda_p_q & ~sda_m2_q;
   assign stop_seen = scl_m2_q & scl_p_q & ~sda_p_q & sda_m2_q;
   // ---------------------------------------------------------------
   // byte engine
   // ---------------------------------------------------------------
   pllc_dev_state_e state_q;
   logic [7:0] shift_q, cfg0_q, cfg1_q, cfg2_q, tx_byte;
   logic [3:0] bit_cnt_q;
   logic [2:0] rx_cnt_q;
   logic [1:0] tx_idx_q;
   logic master_ack_q, sda_oe_q, byte_done, store_en;
   assign byte_done = scl_fall & (bit_cnt_q == PLLC_BITS_PER_BYTE);
   // dummy bytes skipped, beyond the third latch nothing is stored
   assign store_en = (state_q == D_RX) & byte_done & (rx_cnt_q >= PLLC_DUMMY_BYTES) &
                     (rx_cnt_q < PLLC_DUMMY_BYTES + PLLC_CFG_BYTES);
   // read-back walks the three latches, then zeros
   always_comb begin
      unique case (tx_idx_q)
         2'h0: tx_byte = cfg0_q;
         2'h1: tx_byte = cfg1_q;
         2'h2: tx_byte = cfg2_q;
         default: tx_byte = 8'h00;
      endcase
   end
   // link state machine; sda only moves after a seen falling edge
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= D_IDLE;
         shift_q <= 8'h00;
         bit_cnt_q <= 4'h0;
         rx_cnt_q <= 3'h0;
         tx_idx_q <= 2'h0;
         master_ack_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (start_seen) begin
         state_q <= D_ADDR;
         bit_cnt_q <= 4'h0;
         rx_cnt_q <= 3'h0;
         tx_idx_q <= 2'h0;
         sda_oe_q <= 1'b0;
      end else if (stop_seen) begin
         state_q <= D_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         unique case (state_q)
            D_IDLE, D_IGNORE: sda_oe_q <= 1'b0;
            D_ADDR, D_RX: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_m2_q};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_done) begin
                  bit_cnt_q <= 4'h0;
                  if (state_q == D_RX) begin
                     sda_oe_q <= 1'b1;
                     state_q <= D_RX_ACK;
                     if (rx_cnt_q != PLLC_DUMMY_BYTES + PLLC_CFG_BYTES) begin
                        rx_cnt_q <= rx_cnt_q + 3'h1;
                     end
                  end else if (shift_q[7:1] == PLLC_DEV_ADDR) begin
                     sda_oe_q <= 1'b1;
                     master_ack_q <= shift_q[0];
                     state_q <= D_ADDR_ACK;
                  end else begin
                     state_q <= D_IGNORE;
                  end
               end
            end
            D_ADDR_ACK: begin
               if (scl_fall) begin
                  // direction bit kept in master_ack_q until the ack ends
                  if (master_ack_q) begin
                     shift_q <= tx_byte;
                     sda_oe_q <= ~tx_byte[7];
                     tx_idx_q <= tx_idx_q + 2'h1;
                     state_q <= D_TX;
                  end else begin
                     sda_oe_q <= 1'b0;
                     state_q <= D_RX;
                  end
               end
            end
            D_RX_ACK: begin
               if (scl_fall) begin
                  sda_oe_q <= 1'b0;
                  state_q <= D_RX;
               end
            end
            D_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_q == PLLC_BITS_PER_BYTE - 4'h1) begin
                     bit_cnt_q <= 4'h0;
                     sda_oe_q <= 1'b0;
                     state_q <= D_TX_ACK;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     shift_q <= {shift_q[6:0], 1'b0};
                     sda_oe_q <= ~shift_q[6];
                  end
               end
            end
            D_TX_ACK: begin
               if (scl_rise) begin
                  master_ack_q <= ~sda_m2_q;
               end else if (scl_fall) begin
                  if (master_ack_q) begin
                     shift_q <= tx_byte;
                     sda_oe_q <= ~tx_byte[7];
                     if (tx_idx_q != 2'h3) tx_idx_q <= tx_idx_q + 2'h1;
                     state_q <= D_TX;
                  end else begin
                     state_q <= D_IGNORE;
                  end
               end
            end
            default: begin
               state_q <= D_IDLE;
               sda_oe_q <= 1'b0;
            end
         endcase
      end
   end
   // open drain: output level fixed low, enable means pull
   assign link.d_sda_o = 1'b0;
   assign link.d_sda_oe = sda_oe_q;
   // ---------------------------------------------------------------
   // configuration latches
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg0_q <= PLLC_CFG0_RST;
         cfg1_q <= PLLC_CFG1_RST;
         cfg2_q <= PLLC_CFG2_RST;
      end else if (store_en) begin
         unique case (rx_cnt_q - PLLC_DUMMY_BYTES)
            3'h0: cfg0_q <= shift_q;
            3'h1: cfg1_q <= shift_q;
            default: cfg2_q <= shift_q;
         endcase
      end
   end
   assign ref_count_bypass = cfg0_q[PLLC_BYP_BIT];
   assign serial_ratio_select = cfg0_q[PLLC_SEL_BIT];
   assign ref_count = cfg0_q[5:0];
   assign feedback_divider_count = cfg1_q;
   assign reserved_config_byte = cfg2_q;
   // ---------------------------------------------------------------
   // divider selection and synthesized frequency
   // ---------------------------------------------------------------
   logic [9:0] fb_d, fb_q;
   logic [6:0] ref_d, ref_q;
   logic [31:0] freq_q;
   // pin table unless the serial counts are selected
   always_comb begin
      if (serial_ratio_select) begin
         fb_d = ({2'b00, cfg1_q} + PLLC_FB_OFFSET) << 1;
         ref_d = ref_count_bypass ? PLLC_REF_BYPASS
                                  : {1'b0, cfg0_q[5:0]} + PLLC_REF_OFFSET;
      end else begin
         fb_d = sel_m2_q ? PLLC_MULT_X8 : PLLC_MULT_X16;
         ref_d = PLLC_REF_BYPASS;
      end
   end
   // divide is registered so it sits off the latch path
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fb_q <= PLLC_MULT_X8;
         ref_q <= PLLC_REF_BYPASS;
         freq_q <= 32'h0000_0000;
      end else begin
         fb_q <= fb_d;
         ref_q <= ref_d;
         freq_q <= (XTAL_KHZ * {22'h0, fb_q}) / {25'h0, ref_q};
      end
   end
   assign fb_divider = fb_q;
   assign ref_divider = ref_q;
   assign synth_freq_khz = freq_q;
   // ---------------------------------------------------------------
   // output clock gating
   // ---------------------------------------------------------------
   // disabled pair rests both low; enable is a synced pin, edges may glitch
   assign clock_out = pll_clk & oe_m2_q;
   assign clock_out_complement = ~pll_clk & oe_m2_q;
endmodule

// file: hw/pllc_link_if.sv
// open-drain two-wire link between controller and clock synthesizer
`timescale 1ns/1ps
interface pllc_link_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl_line;
   logic sda_line;
   // pull-up wins unless some party pulls low
   assign scl_line = ~(m_scl_oe & ~m_scl_o);
   assign sda_line = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
   modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                   input scl_line, input sda_line);
   modport device (output d_sda_o, output d_sda_oe, input scl_line, input sda_line);
endinterface

// file: hw/pllc_master.sv
// two-wire bus controller with wishbone command registers
`timescale 1ns/1ps
module pllc_master
   import pllc_pkg::*;
#(
   parameter int QTR_CYC = PLLC_QTR_CYC
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   pllc_link_if.master link,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   // ---------------------------------------------------------------
   // wishbone slave
   // ---------------------------------------------------------------
   pllc_mst_state_e state_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [7:0] tx_q, rx_q, shift_q;
   logic got_ack_q, bus_active_q, rd_q, nack_q;
   logic busy, wr_ctrl;

   assign busy = (state_q != M_IDLE);
   // writes act on the edge where ack is seen high
   assign wr_ctrl = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0] &
                    (wb_adr_i == PLLC_REG_CTRL) & ~busy;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         tx_q <= 8'h00;
      end else begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
         if (wb_cyc_i & wb_stb_i & ~ack_q) begin
            unique case (wb_adr_i)
               PLLC_REG_TXDATA: dat_q <= {24'h000000, tx_q};
               PLLC_REG_RXDATA: dat_q <= {24'h000000, rx_q};
               PLLC_REG_STATUS: dat_q <= {29'h0, bus_active_q, got_ack_q, busy};
               default: dat_q <= 32'h0000_0000;
            endcase
         end
         if (wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0] &
             (wb_adr_i == PLLC_REG_TXDATA)) begin
            tx_q <= wb_dat_i[7:0];
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ---------------------------------------------------------------
   // data line synchroniser
   // ---------------------------------------------------------------
   logic sda_m1_q, sda_m2_q;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sda_m1_q <= 1'b1;
         sda_m2_q <= 1'b1;
      end else begin
         sda_m1_q <= link.sda_line;
         sda_m2_q <= sda_m1_q;
      end
   end

   // ---------------------------------------------------------------
   // bit sequencer: four quarter periods per bit
   // ---------------------------------------------------------------
   logic [15:0] qcnt_q;
   logic [1:0] phase_q;
   logic [3:0] bit_q;
   logic scl_pull_q, sda_pull_q;
   logic tick;

   assign tick = (qcnt_q == 16'(QTR_CYC - 1));

   // no clock stretching: the far end never holds the clock
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= M_IDLE;
         qcnt_q <= 16'h0000;
         phase_q <= 2'h0;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         rx_q <= 8'h00;
         got_ack_q <= 1'b0;
         bus_active_q <= 1'b0;
         rd_q <= 1'b0;
         nack_q <= 1'b0;
         scl_pull_q <= 1'b0;
         sda_pull_q <= 1'b0;
      end else begin
         qcnt_q <= (busy & ~tick) ? qcnt_q + 16'h0001 : 16'h0000;
         unique case (state_q)
            M_IDLE: begin
               phase_q <= 2'h0;
               bit_q <= 4'h0;
               if (wr_ctrl) begin
                  rd_q <= wb_dat_i[PLLC_CMD_READ] & ~wb_dat_i[PLLC_CMD_WRITE];
                  nack_q <= wb_dat_i[PLLC_CMD_NACK];
                  shift_q <= tx_q;
                  if (wb_dat_i[PLLC_CMD_START]) begin
                     state_q <= M_START;
                  end else if (wb_dat_i[PLLC_CMD_WRITE] | wb_dat_i[PLLC_CMD_READ]) begin
                     state_q <= M_BIT;
                  end else if (wb_dat_i[PLLC_CMD_STOP]) begin
                     state_q <= M_STOP;
                  end
               end
            end
            M_START: begin
               if (tick) begin
                  phase_q <= phase_q + 2'h1;
                  unique case (phase_q)
                     2'h0: sda_pull_q <= 1'b0;
                     2'h1: scl_pull_q <= 1'b0;
                     2'h2: sda_pull_q <= 1'b1;
                     default: begin
                        scl_pull_q <= 1'b1;
                        bus_active_q <= 1'b1;
                        state_q <= M_IDLE;
                     end
                  endcase
               end
            end
            M_BIT: begin
               if (tick) begin
                  phase_q <= phase_q + 2'h1;
                  unique case (phase_q)
                     // data set only with the clock low
                     2'h0: begin
                        if (bit_q == PLLC_BITS_PER_BYTE) begin
                           sda_pull_q <= rd_q & ~nack_q;
                        end else begin
                           sda_pull_q <= ~rd_q & ~shift_q[7];
                        end
                     end
                     2'h1: scl_pull_q <= 1'b0;
                     2'h2: begin
                        if (bit_q == PLLC_BITS_PER_BYTE) begin
                           got_ack_q <= rd_q ? ~nack_q : ~sda_m2_q;
                        end else begin
                           shift_q <= {shift_q[6:0], sda_m2_q};
                        end
                     end
                     default: begin
                        scl_pull_q <= 1'b1;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == PLLC_BITS_PER_BYTE) begin
                           if (rd_q) begin
                              rx_q <= shift_q;
                           end
                           state_q <= M_IDLE;
                        end
                     end
                  endcase
               end
            end
            M_STOP: begin
               if (tick) begin
                  phase_q <= phase_q + 2'h1;
                  unique case (phase_q)
                     2'h0: sda_pull_q <= 1'b1;
                     2'h1: scl_pull_q <= 1'b0;
                     2'h2: sda_pull_q <= 1'b0;
                     default: begin
                        bus_active_q <= 1'b0;
                        state_q <= M_IDLE;
                     end
                  endcase
               end
            end
            default: state_q <= M_IDLE;
         endcase
      end
   end

   // open drain on both lines
   assign link.m_scl_o = 1'b0;
   assign link.m_scl_oe = scl_pull_q;
   assign link.m_sda_o = 1'b0;
   assign link.m_sda_oe = sda_pull_q;
endmodule

// file: hw/pllc_pkg.sv
// shared constants and types for the pll ratio serial configuration link
package pllc_pkg;
   // ---------------------------------------------------------------
   // link protocol
   // ---------------------------------------------------------------
   localparam logic [6:0] PLLC_DEV_ADDR = 7'h65;
   localparam logic [2:0] PLLC_DUMMY_BYTES = 3'h2;
   localparam logic [2:0] PLLC_CFG_BYTES = 3'h3;
   localparam logic [3:0] PLLC_BITS_PER_BYTE = 4'h8;
   // ---------------------------------------------------------------
   // configuration fields and reset values
   // ---------------------------------------------------------------
   localparam int PLLC_BYP_BIT = 7;
   localparam int PLLC_SEL_BIT = 6;
   localparam logic [7:0] PLLC_CFG0_RST = 8'h00;
   localparam logic [7:0] PLLC_CFG1_RST = 8'h00;
   localparam logic [7:0] PLLC_CFG2_RST = 8'h00;
   localparam logic [9:0] PLLC_FB_OFFSET = 10'h003;
   localparam logic [6:0] PLLC_REF_OFFSET = 7'h02;
   localparam logic [6:0] PLLC_REF_BYPASS = 7'h01;
   localparam logic [9:0] PLLC_MULT_X16 = 10'h010;
   localparam logic [9:0] PLLC_MULT_X8 = 10'h008;
   localparam logic [31:0] PLLC_XTAL_KHZ = 32'h0000_61A8;
   // ---------------------------------------------------------------
   // controller registers (byte addresses) and command bits
   // ---------------------------------------------------------------
   localparam logic [4:0] PLLC_REG_CTRL = 5'h00;
   localparam logic [4:0] PLLC_REG_TXDATA = 5'h04;
   localparam logic [4:0] PLLC_REG_RXDATA = 5'h08;
   localparam logic [4:0] PLLC_REG_STATUS = 5'h0C;
   localparam int PLLC_CMD_START = 0;
   localparam int PLLC_CMD_STOP = 1;
   localparam int PLLC_CMD_WRITE = 2;
   localparam int PLLC_CMD_READ = 3;
   localparam int PLLC_CMD_NACK = 4;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int PLLC_CLK_NS = 25;
   localparam int PLLC_SCL_PERIOD_NS = 10000;
   localparam int PLLC_QTR_CYC = PLLC_SCL_PERIOD_NS / (4 * PLLC_CLK_NS);
   // ---------------------------------------------------------------
   // state machines
   // ---------------------------------------------------------------
   typedef enum logic [7:0] {
      D_IDLE = 8'h01, D_ADDR = 8'h02, D_ADDR_ACK = 8'h04, D_RX = 8'h08,
      D_RX_ACK = 8'h10, D_TX = 8'h20, D_TX_ACK = 8'h40, D_IGNORE = 8'h80
   } pllc_dev_state_e;
   typedef enum logic [3:0] {
      M_IDLE = 4'h1, M_START = 4'h2, M_BIT = 4'h4, M_STOP = 4'h8
   } pllc_mst_state_e;
endpackage

// file: tb/pllc_link_asserts.sv
// concurrent checks on the two-wire link between controller and synthesizer
`timescale 1ns/1ps
module pllc_link_asserts (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic m_scl_o,
   input wire logic m_scl_oe,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic scl_line,
   input wire logic sda_line
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   logic [7:0] rise_q;
   // -----------------------------------------------------------
   // framing helper and properties
   // -----------------------------------------------------------
   // clock rises since the last start; a stop adds one more rise
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) rise_q <= 8'h00;
      else if (scl_line && $fell(sda_line)) rise_q <= 8'h00;
      else if ($rose(scl_line)) rise_q <= rise_q + 8'h01;
   end
   sequence s_start; scl_line && $fell(sda_line); endsequence
   sequence s_stop; scl_line && $rose(sda_line); endsequence
   property p_scl_low_only; !m_scl_o; endproperty
   a_scl_low_only: assert property (p_scl_low_only) else $error("clock driven high");
   property p_sda_low_only; !m_sda_o && !d_sda_o; endproperty
   a_sda_low_only: assert property (p_sda_low_only) else $error("data driven high");
   property p_start_clock; s_start |-> ##[1:40] !scl_line; endproperty
   a_start_clock: assert property (p_start_clock) else $error("no clock after start");
   property p_whole_bytes; s_stop |-> (rise_q % 8'd9) == 8'd1; endproperty
   a_whole_bytes: assert property (p_whole_bytes) else $error("partial byte");
   property p_high_stable; $rose(scl_line) |=> $stable(sda_line) [*6]; endproperty
   a_high_stable: assert property (p_high_stable) else $error("data moved in high");
   property p_dev_change_low; $changed(d_sda_oe) |-> !scl_line; endproperty
   a_dev_change_low: assert property (p_dev_change_low) else $error("device moved");
   property p_ack_hold; d_sda_oe && $rose(scl_line) |-> d_sda_oe [*8]; endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
   property p_stop_idle; s_stop |=> !d_sda_oe [*8]; endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("device busy after stop");
   property p_addr_quiet; s_start |=> !d_sda_oe [*8]; endproperty
   a_addr_quiet: assert property (p_addr_quiet) else $error("device early");
endmodule

// file: tb/tb_pll_ratio_serial_config.sv
// self-checking bench: controller and synthesizer joined over the two-wire link
`timescale 1ns/1ps
module tb_pll_ratio_serial_config;
   import pllc_pkg::*;
   logic ref_clk = 1'b0, arst_n = 1'b0, req = 1'b0, we = 1'b0, ack;
   logic sel_pin = 1'b1, oe_pin = 1'b0, pll_clk = 1'b0, byp, rsel, cko, ckb;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h0, st = 32'h0;
   logic [31:0] rdat, frq;
   logic [5:0] rcnt;
   logic [7:0] fcnt, rsv;
   logic [9:0] fbd;
   logic [6:0] rfd;
   int mismatches = 0, samples_checked = 0, cycles = 0;
   pllc_link_if lk ();
   pllc_master #(.QTR_CYC(8)) i_pllc_master (.ref_clk, .arst_n, .link(lk), .wb_cyc_i(req),
      .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack));
   pllc_device i_pllc_device (.ref_clk, .arst_n, .link(lk), .mult_select_pin(sel_pin),
      .output_enable_pin(oe_pin), .pll_clk, .ref_count_bypass(byp), .serial_ratio_select(rsel),
      .ref_count(rcnt), .feedback_divider_count(fcnt), .reserved_config_byte(rsv),
      .fb_divider(fbd), .ref_divider(rfd), .synth_freq_khz(frq), .clock_out(cko),
      .clock_out_complement(ckb));
   pllc_link_asserts i_pllc_link_asserts (.ref_clk, .arst_n, .m_scl_o(lk.m_scl_o),
      .m_scl_oe(lk.m_scl_oe), .m_sda_o(lk.m_sda_o), .m_sda_oe(lk.m_sda_oe),
      .d_sda_o(lk.d_sda_o), .d_sda_oe(lk.d_sda_oe), .scl_line(lk.scl_line),
      .sda_line(lk.sda_line));
   // -----------------------------------------------------------
   // clocks, watchdog and shared tasks
   // -----------------------------------------------------------
   always #12.5 ref_clk = ~ref_clk;
   // watchdog sized well above the ~6k cycles of traffic
   always @(posedge ref_clk) begin
      pll_clk <= ~pll_clk;
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge ref_clk); while (ack !== 1'b1);
      st = rdat;
      req <= 1'b0;
   endtask
   task automatic op(input logic [7:0] c);
      wb(1'b1, PLLC_REG_CTRL, {24'h0, c});
      do wb(1'b0, PLLC_REG_STATUS, 32'h0); while (st[0] !== 1'b0);
   endtask
   task automatic tx(input logic [7:0] b, input logic a);
      wb(1'b1, PLLC_REG_TXDATA, {24'h0, b});
      op(8'h04);
      chk(32'(st[1]), 32'(a));
   endtask
   task automatic rx(input logic [7:0] c, input logic [7:0] e);
      op(c);
      wb(1'b0, PLLC_REG_RXDATA, 32'h0);
      chk(st, {24'h0, e});
   endtask
   task automatic prog(input logic [7:0] c0, input logic [7:0] c1);
      op(8'h01);
      tx(8'hCA, 1'b1);
      tx(8'hA5, 1'b1);
      tx(8'h5A, 1'b1);
      tx(c0, 1'b1);
      tx(c1, 1'b1);
      tx(8'h3C, 1'b1);
      tx(8'hE7, 1'b1);
      op(8'h02);
      repeat (8) @(posedge ref_clk);
   endtask
   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task automatic t_pin_table();
      chk(32'({byp, rsel}), 32'h0);
      chk(32'(fbd), 32'h8);
      chk(frq, 32'(PLLC_XTAL_KHZ * 8));
      sel_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk(32'(fbd), 32'h10);
   endtask
   task automatic t_program();
      prog(8'h45, 8'h10);
      chk(32'({byp, rsel, rcnt, fcnt, rsv}), 32'h0045_103C);
      chk(32'({fbd, rfd}), 32'({10'd38, 7'd7}));
      chk(frq, 32'(PLLC_XTAL_KHZ * 38 / 7));
      prog(8'hC5, 8'hFF);
      chk(32'({fbd, rfd}), 32'({10'd516, 7'd1}));
   endtask
   // wrong address: no ack, bytes ignored, latches kept
   task automatic t_foreign();
      op(8'h01);
      chk(32'(st[2]), 32'h1);
      tx(8'hC8, 1'b0);
      tx(8'h00, 1'b0);
      op(8'h02);
      chk(st, 32'h0);
      chk(32'(fcnt), 32'hFF);
   endtask
   task automatic t_readback();
      op(8'h01);
      tx(8'hCB, 1'b1);
      rx(8'h08, 8'hC5);
      wb(1'b0, PLLC_REG_STATUS, 32'h0);
      chk(32'(st[1]), 32'h1);
      rx(8'h18, 8'hFF);
      wb(1'b0, PLLC_REG_STATUS, 32'h0);
      chk(32'(st[1]), 32'h0);
      op(8'h02);
   endtask
   task automatic t_gate();
      repeat (4) @(negedge ref_clk);
      chk(32'({cko, ckb}), 32'h0);
      @(posedge ref_clk);
      oe_pin <= 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(32'({cko, ckb}), 32'({pll_clk, ~pll_clk}));
      @(negedge ref_clk);
      chk(32'({cko, ckb}), 32'({pll_clk, ~pll_clk}));
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_pin_table();
      t_program();
      t_foreign();
      t_readback();
      t_gate();
      wrap_up();
   end
endmodule
